// >>> src/math_block_regs.vh
// register offsets, field codes and fixed-point constants for the math blocks
`ifndef MATH_BLOCK_REGS_VH
`define MATH_BLOCK_REGS_VH

// =====================================================================
// register offsets within one block (address bits 5:0, block in 7:6)
`define REG_CTRL 6'h00
`define REG_OUT_MIN 6'h01
`define REG_OUT_MAX 6'h02
`define REG_FUNC_SEL 6'h03
`define REG_OUT_VAL 6'h04
`define REG_OUT_PCT 6'h05
`define REG_IN_BASE 6'h08
`define REG_IN_END 6'h18

// fields inside each four-word input group
`define IN_SRC 2'h0
`define IN_MIN 2'h1
`define IN_MAX 2'h2
`define IN_WEIGHT 2'h3

// source word layout: code [1:0], number [4:2], function number [6:5]
`define SRC_UNUSED 2'h0
`define SRC_EXT 2'h1
`define SRC_MATH 2'h2

// =====================================================================
// reset values
`define RST_OUT_MIN 16'h0000
`define RST_OUT_MAX 16'h0064
`define RST_WEIGHT 16'h1000
`define RST_IN_LIMIT 16'h0000

// =====================================================================
// fixed point: signed Q4.12, full scale 100 % equals one
`define PCT_ONE 32'h00001000
`define PCT_NEG_ONE 32'hFFFFF000
`define PCT_HALF 32'h00000800
`define FRAC_BITS 12

// function selector codes
`define FN_EQ 4'h0
`define FN_NE 4'h1
`define FN_GT 4'h2
`define FN_GE 4'h3
`define FN_LT 4'h4
`define FN_LE 4'h5
`define FN_OR 4'h6
`define FN_AND 4'h7
`define FN_XOR 4'h8
`define FN_ADD 4'h9
`define FN_SUB 4'hA
`define FN_MUL 4'hB
`define FN_DIV 4'hC
`define FN_MIN 4'hD
`define FN_MAX 4'hE

// divider length in clock cycles
`define DIV_CYCLES 6'h20

`endif

// >>> src/pct_divider.v
// iterative unsigned restoring divider shared by the input scaling and quotient steps
`timescale 1ns/100ps
`default_nettype none
`include "math_block_regs.vh"

module pct_divider (
   // clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   // request
   input wire start_in,
   input wire [31:0] dividend_in,
   input wire [17:0] divisor_in,
   // answer
   output wire [31:0] quotient_out,
   output wire done_out
);

   reg [31:0] quo_q;
   reg [17:0] rem_q;
   reg [17:0] den_q;
   reg [5:0] cnt_q;
   reg run_q;
   reg done_q;

   // =====================================================================
   // one quotient bit per cycle; slow but a single small subtractor
   wire [18:0] shifted = {rem_q, quo_q[31]};
   wire ge = (shifted >= {1'b0, den_q});
   wire [18:0] trial = shifted - {1'b0, den_q};

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         quo_q <= 32'h00000000;
         rem_q <= 18'h00000;
         den_q <= 18'h00000;
         cnt_q <= 6'h00;
         run_q <= 1'b0;
         done_q <= 1'b0;
      end else if (start_in) begin
         quo_q <= dividend_in;
         rem_q <= 18'h00000;
         den_q <= divisor_in;
         cnt_q <= `DIV_CYCLES;
         run_q <= 1'b1;
         done_q <= 1'b0;
      end else if (run_q) begin
         rem_q <= ge ? trial[17:0] : shifted[17:0];
         quo_q <= {quo_q[30:0], ge};
         cnt_q <= cnt_q - 6'h01;
         run_q <= (cnt_q != 6'h01);
         done_q <= (cnt_q == 6'h01);
      end else begin
         done_q <= 1'b0;
      end
   end

   assign quotient_out = quo_q;
   assign done_out = done_q;

endmodule
`default_nettype wire

// >>> src/chained_math_function_block.v
// four chained math function blocks with register port and shared divider
`timescale 1ns/100ps
`default_nettype none
`include "math_block_regs.vh"

// Function
// - four blocks, four inputs each
// - inputs normalised to percent of limits
// - normalised input times signed weight
// - codes 0-5 compare first against second
// - codes 6-8 are OR, AND, XOR
// - codes 9-14 sum difference product quotient min max
// - function chain: in1/in2, then in3, in4
// - self source takes chosen intermediate or final
// - other blocks only see final outputs
// - unused input skips function, earlier result out
// - boolean true when operand at least half
// - compare and boolean results only zero/one
// - erroneous input replaced by zero
// - divide by zero gives zero
// - negative difference clamps unless weights negative
// - final percent mapped onto output range
// - output limits offered to downstream consumers
module chained_math_function_block (
   // clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   // register port
   input wire [7:0] reg_addr_in,
   input wire [15:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output wire [15:0] reg_rdata_out,
   // processing tick and source signals
   input wire tick_in,
   input wire [127:0] src_value_in,
   input wire [7:0] src_error_in,
   // results toward downstream blocks
   output wire [63:0] math_value_out,
   output wire [63:0] math_min_out,
   output wire [63:0] math_max_out,
   output wire eval_done_out,
   output wire busy_out
);

   localparam S_IDLE = 2'h0;
   localparam S_PREP = 2'h1;
   localparam S_DIV = 2'h2;
   // full-width copies so the saturation limits are cut on purpose
   localparam [31:0] ONE_32 = `PCT_ONE;
   localparam [31:0] NEG_ONE_32 = `PCT_NEG_ONE;

   integer k;
   integer j;

   // configuration
   reg [3:0] en_q;
   reg [15:0] omin_q [0:3];
   reg [15:0] omax_q [0:3];
   reg [11:0] fsel_q [0:3];
   reg [6:0] isrc_q [0:15];
   reg [15:0] imin_q [0:15];
   reg [15:0] imax_q [0:15];
   reg [15:0] iwt_q [0:15];
   // evaluation state
   reg [1:0] state_q;
   reg [1:0] blk_q;
   reg [2:0] step_q;
   reg signed [15:0] opnd_q [0:3];
   reg [3:0] unused_q;
   reg [3:0] negw_q;
   reg signed [15:0] res_q [0:15];
   reg signed [15:0] fin_q;
   reg signed [15:0] pct_q [0:3];
   reg [15:0] out_q [0:3];
   reg done_q;
   reg [15:0] rdata_q;

   // =====================================================================
   // helpers
   function signed [31:0] sx;
      input [15:0] v;
      begin
         sx = {{16{v[15]}}, v};
      end
   endfunction

   function signed [15:0] sat;
      input signed [31:0] v;
      begin
         if (v > $signed(`PCT_ONE))
            sat = ONE_32[15:0];
         else if (v < $signed(`PCT_NEG_ONE))
            sat = NEG_ONE_32[15:0];
         else
            sat = v[15:0];
      end
   endfunction

   // =====================================================================
   // register write side
   wire [5:0] roff = reg_addr_in[5:0];
   wire [1:0] rblk = reg_addr_in[7:6];
   wire [5:0] rin = roff - `REG_IN_BASE;
   wire [3:0] ridx = {rblk, rin[3:2]};
   wire rin_hit = (roff >= `REG_IN_BASE) && (roff < `REG_IN_END);

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         en_q <= 4'h0;
         for (k = 0; k < 4; k = k + 1) begin
            omin_q[k] <= `RST_OUT_MIN;
            omax_q[k] <= `RST_OUT_MAX;
            fsel_q[k] <= 12'h000;
         end
         for (k = 0; k < 16; k = k + 1) begin
            isrc_q[k] <= 7'h00;
            imin_q[k] <= `RST_IN_LIMIT;
            imax_q[k] <= `RST_IN_LIMIT;
            iwt_q[k] <= `RST_WEIGHT;
         end
      end else if (reg_wr_in) begin
         if (roff == `REG_CTRL)
            en_q[rblk] <= reg_wdata_in[0];
         if (roff == `REG_OUT_MIN)
            omin_q[rblk] <= reg_wdata_in;
         if (roff == `REG_OUT_MAX)
            omax_q[rblk] <= reg_wdata_in;
         if (roff == `REG_FUNC_SEL)
            fsel_q[rblk] <= reg_wdata_in[11:0];
         if (rin_hit && rin[1:0] == `IN_SRC)
            isrc_q[ridx] <= reg_wdata_in[6:0];
         if (rin_hit && rin[1:0] == `IN_MIN)
            imin_q[ridx] <= reg_wdata_in;
         if (rin_hit && rin[1:0] == `IN_MAX)
            imax_q[ridx] <= reg_wdata_in;
         if (rin_hit && rin[1:0] == `IN_WEIGHT)
            iwt_q[ridx] <= reg_wdata_in;
      end
   end

   // read mux; data valid only in the cycle after the strobe
   reg [15:0] rd_mux;
   always @* begin
      rd_mux = 16'h0000;
      if (roff == `REG_CTRL)
         rd_mux = {14'h0000, busy_out, en_q[rblk]};
      else if (roff == `REG_OUT_MIN)
         rd_mux = omin_q[rblk];
      else if (roff == `REG_OUT_MAX)
         rd_mux = omax_q[rblk];
      else if (roff == `REG_FUNC_SEL)
         rd_mux = {4'h0, fsel_q[rblk]};
      else if (roff == `REG_OUT_VAL)
         rd_mux = out_q[rblk];
      else if (roff == `REG_OUT_PCT)
         rd_mux = pct_q[rblk];
      else if (rin_hit && rin[1:0] == `IN_SRC)
         rd_mux = {9'h000, isrc_q[ridx]};
      else if (rin_hit && rin[1:0] == `IN_MIN)
         rd_mux = imin_q[ridx];
      else if (rin_hit && rin[1:0] == `IN_MAX)
         rd_mux = imax_q[ridx];
      else if (rin_hit)
         rd_mux = iwt_q[ridx];
   end

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in)
         rdata_q <= 16'h0000;
      else
         rdata_q <= reg_rd_in ? rd_mux : 16'h0000;
   end

   // =====================================================================
   // step datapath: steps 0-3 inputs, 4-6 functions, 7 output mapping
   wire [3:0] ii = {blk_q, step_q[1:0]};
   wire [1:0] code = isrc_q[ii][1:0];
   wire [2:0] num = isrc_q[ii][4:2];
   wire [1:0] fnum = isrc_q[ii][6:5];
   wire [11:0] sel_all = fsel_q[blk_q];
   wire [3:0] sel = sel_all[{step_q[1:0], 2'b00} +: 4];
   wire [31:0] div_q;
   wire div_done;

   reg [15:0] raw, lo, hi;
   reg in_norm, in_unused, need_div, skip, ta, tb, dsign, negw_any;
   reg signed [31:0] diff, span, direct_v, a, b, prev_v, prod;
   reg signed [31:0] finc, mapped;
   reg [31:0] dvd, aa, ab;
   reg [17:0] dvs;

   always @* begin
      raw = 16'h0000;
      lo = 16'h0000;
      hi = 16'h0000;
      in_norm = 1'b0;
      in_unused = 1'b0;
      need_div = 1'b0;
      direct_v = 32'sd0;
      dvd = 32'h00000000;
      dvs = 18'h00000;
      case (code)
         `SRC_EXT: begin
            raw = src_value_in[{num, 4'h0} +: 16];
            lo = imin_q[ii];
            hi = imax_q[ii];
            in_norm = ~src_error_in[num];
         end
         `SRC_MATH: begin
            if (num[1:0] == blk_q) begin
               if (fnum == 2'h0)
                  direct_v = sx(pct_q[blk_q]);
               else
                  direct_v = sx(res_q[{blk_q, fnum - 2'h1}]);
            end else begin
               raw = out_q[num[1:0]];
               lo = omin_q[num[1:0]];
               hi = omax_q[num[1:0]];
               in_norm = 1'b1;
            end
         end
         default: in_unused = 1'b1;
      endcase
      diff = sx(raw) - sx(lo);
      span = sx(hi) - sx(lo);
      // function operands follow the chain
      a = (step_q[1:0] == 2'h0) ? sx(opnd_q[0]) :
         sx(res_q[{blk_q, step_q[1:0] - 2'h1}]);
      b = sx(opnd_q[step_q[1:0] + 2'h1]);
      prev_v = (step_q[1:0] == 2'h0) ? 32'sd0 : a;
      skip = unused_q[step_q[1:0] + 2'h1] ||
         (step_q[1:0] == 2'h0 && unused_q[0]);
      ta = (a >= $signed(`PCT_HALF));
      tb = (b >= $signed(`PCT_HALF));
      aa = a[31] ? -a : a;
      ab = b[31] ? -b : b;
      dsign = a[31] ^ b[31];
      negw_any = |(negw_q & ((step_q[1:0] == 2'h0) ? 4'h3 :
         (step_q[1:0] == 2'h1) ? 4'h7 : 4'hF));
      prod = (a * b) >>> `FRAC_BITS;
      if (!step_q[2]) begin
         if (in_norm) begin
            if (span <= 0 || diff <= 0)
               direct_v = 32'sd0;
            else if (diff >= span)
               direct_v = `PCT_ONE;
            else begin
               need_div = 1'b1;
               dvd = diff <<< `FRAC_BITS;
               dvs = span[17:0];
            end
         end
      end else begin
         case (sel)
            `FN_EQ: direct_v = (a == b) ? `PCT_ONE : 32'sd0;
            `FN_NE: direct_v = (a != b) ? `PCT_ONE : 32'sd0;
            `FN_GT: direct_v = (a > b) ? `PCT_ONE : 32'sd0;
            `FN_GE: direct_v = (a >= b) ? `PCT_ONE : 32'sd0;
            `FN_LT: direct_v = (a < b) ? `PCT_ONE : 32'sd0;
            `FN_LE: direct_v = (a <= b) ? `PCT_ONE : 32'sd0;
            `FN_OR: direct_v = (ta | tb) ? `PCT_ONE : 32'sd0;
            `FN_AND: direct_v = (ta & tb) ? `PCT_ONE : 32'sd0;
            `FN_XOR: direct_v = (ta ^ tb) ? `PCT_ONE : 32'sd0;
            `FN_ADD: direct_v = a + b;
            `FN_SUB: begin
               direct_v = a - b;
               if (direct_v < 0 && !negw_any)
                  direct_v = 32'sd0;
            end
            `FN_MUL: direct_v = prod;
            `FN_DIV: begin
               direct_v = 32'sd0;
               if (b != 0) begin
                  need_div = 1'b1;
                  dvd = aa << `FRAC_BITS;
                  dvs = ab[17:0];
               end
            end
            `FN_MIN: direct_v = (a < b) ? a : b;
            `FN_MAX: direct_v = (a > b) ? a : b;
            default: direct_v = 32'sd0;
         endcase
      end
      // final percent clipped to 0..100 % before range mapping
      finc = (fin_q < 0) ? 32'sd0 : sx(fin_q);
      mapped = sx(omin_q[blk_q]) +
         ((finc * (sx(omax_q[blk_q]) - sx(omin_q[blk_q]))) >>>
         `FRAC_BITS);
   end

   // divider answer, saturated and signed back for quotients
   wire [31:0] div_mag = (div_q > `PCT_ONE) ? `PCT_ONE : div_q;
   wire signed [31:0] div_v = (step_q[2] && dsign) ? -div_mag : div_mag;

   wire live = (state_q == S_PREP) && (step_q != 3'h7) &&
      !(step_q[2] && skip);
   wire div_start = live && need_div;
   wire commit = (live && !need_div) || (state_q == S_DIV && div_done);
   wire signed [31:0] commit_v = (state_q == S_DIV) ? div_v : direct_v;
   wire signed [31:0] weighed = (commit_v * sx(iwt_q[ii])) >>> `FRAC_BITS;

   pct_divider divider_i (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .start_in(div_start),
      .dividend_in(dvd),
      .divisor_in(dvs),
      .quotient_out(div_q),
      .done_out(div_done)
   );

   // =====================================================================
   // sequencer: one block after another, steps strictly in order
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= S_IDLE;
         blk_q <= 2'h0;
         step_q <= 3'h0;
         unused_q <= 4'h0;
         negw_q <= 4'h0;
         fin_q <= 16'h0000;
         done_q <= 1'b0;
         for (j = 0; j < 4; j = j + 1) begin
            opnd_q[j] <= 16'h0000;
            pct_q[j] <= 16'h0000;
            out_q[j] <= 16'h0000;
         end
         for (j = 0; j < 16; j = j + 1)
            res_q[j] <= 16'h0000;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (tick_in) begin
                  state_q <= S_PREP;
                  blk_q <= 2'h0;
                  step_q <= 3'h0;
               end
            end
            S_PREP: begin
               if (step_q == 3'h7) begin
                  out_q[blk_q] <= en_q[blk_q] ?
                     mapped[15:0] : 16'h0000;
                  pct_q[blk_q] <= en_q[blk_q] ? fin_q : 16'sh0000;
                  step_q <= 3'h0;
                  blk_q <= blk_q + 2'h1;
                  if (blk_q == 2'h3) begin
                     state_q <= S_IDLE;
                     done_q <= 1'b1;
                  end
               end else if (step_q[2] && skip) begin
                  fin_q <= sat(prev_v);
                  step_q <= 3'h7;
               end else if (need_div) begin
                  state_q <= S_DIV;
               end
            end
            S_DIV: begin
               if (div_done)
                  state_q <= S_PREP;
            end
            default: state_q <= S_IDLE;
         endcase
         // result of an input or function step
         if (commit) begin
            if (!step_q[2]) begin
               opnd_q[step_q[1:0]] <= sat(weighed);
               negw_q[step_q[1:0]] <= iwt_q[ii][15];
               unused_q[step_q[1:0]] <= in_unused;
               step_q <= step_q + 3'h1;
            end else begin
               res_q[{blk_q, step_q[1:0]}] <= sat(commit_v);
               if (step_q == 3'h6)
                  fin_q <= sat(commit_v);
               step_q <= step_q + 3'h1;
            end
         end
      end
   end

   // =====================================================================
   // per-block output buses
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : pack
         assign math_value_out[16*g +: 16] = out_q[g];
         assign math_min_out[16*g +: 16] = omin_q[g];
         assign math_max_out[16*g +: 16] = omax_q[g];
      end
   endgenerate

   assign reg_rdata_out = rdata_q;
   assign eval_done_out = done_q;
   assign busy_out = (state_q != S_IDLE);

endmodule
`default_nettype wire

// >>> tb/chained_math_properties.sv
// port-level timing checks for the chained math function blocks
`timescale 1ns/100ps
`default_nettype none

module chained_math_checker (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // register port
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   // evaluation and results
   input wire logic tick_in,
   input wire logic [63:0] math_min_out,
   input wire logic [63:0] math_max_out,
   input wire logic eval_done_out,
   input wire logic busy_out
);
   // =====================================================================
   // one clock domain, so one clocking and one reset for all
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   // read data may only appear in the cycle after a read strobe
   property p_rd_idle;
      !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside its cycle");

   // limits offered downstream only move on a register write
   property p_cfg_stable;
      !$past(reg_wr_in) |-> $stable(math_min_out) && $stable(math_max_out);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable)
      else $error("output limits changed without a write");

   // an idle tick starts an evaluation at once
   property p_tick_busy;
      tick_in && !busy_out |=> busy_out;
   endproperty
   a_tick_busy: assert property (p_tick_busy)
      else $error("tick while idle did not start evaluation");

   // an evaluation starts only from a tick
   property p_rose_tick;
      $rose(busy_out) |-> $past(tick_in);
   endproperty
   a_rose_tick: assert property (p_rose_tick)
      else $error("evaluation started without a tick");

   // done is a single-cycle pulse
   property p_done_pulse;
      eval_done_out |=> !eval_done_out;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done longer than one cycle");

   // done marks the end of a busy stretch
   property p_done_idle;
      eval_done_out |-> !busy_out && $past(busy_out);
   endproperty
   a_done_idle: assert property (p_done_idle)
      else $error("done not at end of evaluation");

   // each of the four blocks takes at least two cycles
   property p_busy_min;
      $rose(busy_out) |-> busy_out [*8];
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("evaluation ended too early");

   // every evaluation finishes within its worst case
   property p_eval_bound;
      $rose(busy_out) |-> ##[8:1000] eval_done_out;
   endproperty
   a_eval_bound: assert property (p_eval_bound)
      else $error("evaluation never finished");

   // busy only drops together with done
   property p_fell_done;
      $fell(busy_out) |-> eval_done_out;
   endproperty
   a_fell_done: assert property (p_fell_done)
      else $error("busy dropped without done");
endmodule

bind chained_math_function_block chained_math_checker u_chk (
   .sys_clk_in(sys_clk_in),
   .rst_in(rst_in),
   .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out),
   .tick_in(tick_in),
   .math_min_out(math_min_out),
   .math_max_out(math_max_out),
   .eval_done_out(eval_done_out),
   .busy_out(busy_out)
);
`default_nettype wire

// >>> tb/source_blocks.sv
// far-side producer blocks: eight held source values with error flags
`timescale 1ns/100ps
`default_nettype none

module source_blocks (
   // clock
   input wire logic sys_clk_in,
   // values toward the math blocks
   output logic [127:0] src_value_out,
   output logic [7:0] src_error_out
);
   // producers hold their value as a level until they change it
   initial begin
      src_value_out = 128'h0;
      src_error_out = 8'h00;
   end

   // update one producer just after an edge; error marks out of range
   task put(input int n, input logic [15:0] v, input logic e);
      @(posedge sys_clk_in);
      src_value_out[16*n +: 16] <= v;
      src_error_out[n] <= e;
   endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the chained math function blocks
`timescale 1ns/100ps
`default_nettype none
`include "math_block_regs.vh"

module testbench;
   logic sys_clk_in, rst_in, reg_wr_in, reg_rd_in, tick_in;
   logic [7:0] reg_addr_in;
   logic [15:0] reg_wdata_in, reg_rdata_out, rd_q;
   logic [127:0] src_value_in;
   logic [7:0] src_error_in;
   logic [63:0] math_value_out, math_min_out, math_max_out;
   logic eval_done_out, busy_out;
   int err_total, checks_done, cycles;
   // expected percent per code for operands 0.5 and 0.25
   logic [15:0] exp_tab [15] = '{16'h0000, 16'h1000, 16'h1000, 16'h1000,
      16'h0000, 16'h0000, 16'h1000, 16'h0000, 16'h1000, 16'h0C00,
      16'h0400, 16'h0200, 16'h1000, 16'h0400, 16'h0800};

   // =====================================================================
   // design and far side
   chained_math_function_block DUT (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .tick_in(tick_in),
      .src_value_in(src_value_in), .src_error_in(src_error_in),
      .math_value_out(math_value_out), .math_min_out(math_min_out),
      .math_max_out(math_max_out), .eval_done_out(eval_done_out),
      .busy_out(busy_out));
   source_blocks far (.sys_clk_in(sys_clk_in),
      .src_value_out(src_value_in), .src_error_out(src_error_in));

   // =====================================================================
   // clock and hang guard
   initial begin
      sys_clk_in = 1'b0;
      forever #2 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         give_verdict();
      end
   end

   // =====================================================================
   // tasks: all but cmp16 start and end in the time step of a rising edge
   task automatic give_verdict;
      if (err_total == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one idle cycle after each strobe so no signal is set twice per step
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      rd_q = reg_rdata_out;
      @(posedge sys_clk_in);
      cmp16(rd_q, exp);
   endtask
   task automatic eval;
      int n;
      tick_in <= 1'b1;
      @(posedge sys_clk_in);
      tick_in <= 1'b0;
      n = 0;
      while (eval_done_out !== 1'b1 && n < 1500) begin
         @(posedge sys_clk_in);
         #1;
         n++;
      end
      cmp16({15'h0000, eval_done_out}, 16'h0001);
      @(posedge sys_clk_in);
   endtask
   // source word plus limits 0..100 for one input
   task automatic cfg_in(input logic [1:0] g, input logic [1:0] i,
                         input logic [15:0] s);
      logic [5:0] o;
      o = `REG_IN_BASE + {2'h0, i, 2'h0};
      wr({g, o}, s);
      wr({g, o + 6'h1}, 16'h0000);
      wr({g, o + 6'h2}, 16'h0064);
   endtask
   // block 0: set sources 0 and 1, selectors, evaluate, read percent
   task automatic one_case(input logic [15:0] a, input logic [15:0] b,
      input logic e, input logic [11:0] sel, input logic [15:0] exp);
      far.put(0, a, e);
      far.put(1, b, 1'b0);
      wr({2'h0, `REG_FUNC_SEL}, {4'h0, sel});
      eval();
      rd_chk({2'h0, `REG_OUT_PCT}, exp);
   endtask

   // =====================================================================
   // main sequence
   initial begin
      rst_in = 1'b1;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      tick_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 16'h0000;
      err_total = 0;
      checks_done = 0;
      cycles = 0;
      repeat (2) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      @(posedge sys_clk_in);
      // reset values and an unmapped place
      rd_chk({2'h0, `REG_OUT_MAX}, `RST_OUT_MAX);
      rd_chk({2'h2, `REG_IN_BASE + 6'h3}, `RST_WEIGHT);
      rd_chk({2'h3, 6'h3F}, 16'h0000);
      cmp16(math_max_out[63:48], `RST_OUT_MAX);
      // block 0 with two external inputs; inputs 3 and 4 unused
      wr({2'h0, `REG_CTRL}, 16'h0001);
      rd_chk({2'h0, `REG_CTRL}, 16'h0001);
      cfg_in(2'h0, 2'h0, 16'h0001);
      cfg_in(2'h0, 2'h1, 16'h0005);
      // weights of 1.0 keep arithmetic within full scale
      for (int c = 0; c < 15; c++) begin
         one_case(16'h0032, 16'h0019, 1'b0, c[11:0],
            exp_tab[c]);
      end
      one_case(16'h0031, 16'h0000, 1'b0, 12'h006, 16'h0000);
      one_case(16'h0032, 16'h0000, 1'b0, 12'h006, 16'h1000);
      one_case(16'h0032, 16'h0000, 1'b0, 12'h00C, 16'h0000);
      one_case(16'h0019, 16'h0032, 1'b0, 12'h00A, 16'h0000);
      one_case(16'h0032, 16'h0019, 1'b1, 12'h009, 16'h0400);
      one_case(16'h0064, 16'h0064, 1'b0, 12'h009, 16'h1000);
      // negative weight keeps a negative difference
      wr({2'h0, `REG_IN_BASE + 6'h3}, 16'hF000);
      one_case(16'h0019, 16'h0032, 1'b0, 12'h00A, 16'hF400);
      wr({2'h0, `REG_IN_BASE + 6'h3}, `RST_WEIGHT);
      // limits 20..84 put 52 at half scale
      wr({2'h0, `REG_IN_BASE + 6'h1}, 16'h0014);
      wr({2'h0, `REG_IN_BASE + 6'h2}, 16'h0054);
      one_case(16'h0034, 16'h0000, 1'b0, 12'h009, 16'h0800);
      cfg_in(2'h0, 2'h0, 16'h0001);
      // chain through input 3, input 4 still unused
      far.put(2, 16'h0019, 1'b0);
      cfg_in(2'h0, 2'h2, 16'h0009);
      one_case(16'h0032, 16'h0019, 1'b0, 12'h09A, 16'h0800);
      // input 4 takes own function 1; block 1 sees only the final
      cfg_in(2'h0, 2'h3, 16'h0022);
      wr({2'h1, `REG_CTRL}, 16'h0001);
      cfg_in(2'h1, 2'h0, 16'h0022);
      cfg_in(2'h1, 2'h1, 16'h0005);
      wr({2'h1, `REG_FUNC_SEL}, 16'h000E);
      one_case(16'h0032, 16'h0019, 1'b0, 12'h99A, 16'h0C00);
      rd_chk({2'h1, `REG_OUT_PCT}, 16'h0C00);
      // output range 10..30 maps 75 percent to 25
      wr({2'h0, `REG_OUT_MIN}, 16'h000A);
      wr({2'h0, `REG_OUT_MAX}, 16'h001E);
      cmp16(math_min_out[15:0], 16'h000A);
      cmp16(math_max_out[15:0], 16'h001E);
      eval();
      cmp16(math_value_out[15:0], 16'h0019);
      rd_chk({2'h0, `REG_OUT_VAL}, 16'h0019);
      // a disabled block presents zero
      wr({2'h0, `REG_CTRL}, 16'h0000);
      eval();
      cmp16(math_value_out[15:0], 16'h0000);
      rd_chk({2'h0, `REG_OUT_PCT}, 16'h0000);
      give_verdict();
   end
endmodule
`default_nettype wire
